// [rtl/ics_pkg.sv]
// Purpose: shared constants for the two-wire control port, both ends
// Assumes: 10 MHz ref_clk, bus at fast-mode rate or slower
// Notes: Summary of operation follows
// Summary of operation
// - device acts only as slave, receiver or transmitter
// - bit rate up to 400 kbit/s
// - no response while in deep sleep
// - address upper five bits fixed 11000
// - address low bits follow strap pins
// - address lsb zero writes, one reads
// - write byte after address is sub-address
// - reads: device drives data, master acks
// - system drives enable input for sleep
// - scan input disables normal port operation
// - enable low means deep sleep
// - sixteen registers, sub-addresses 0x0 to 0xF
// - reset input has internal pull-down
package ics_pkg;
  localparam logic [4:0] ADDR_FIXED = 5'h18;
  localparam int REG_COUNT = 16;
  localparam int SUB_W = 4;
  localparam int RATE_BPS = 400000;
  localparam int CLK_HZ = 10000000;
  // quarter bit period in cycles, rounded up so the bus never runs fast
  localparam int QTR_CYC = (CLK_HZ + 4 * RATE_BPS - 1) / (4 * RATE_BPS);
  localparam logic [7:0] REG_RESET [0:15] = '{8'h00, 8'h05, 8'h3A, 8'h05, 8'h00, 8'h20,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h04, 8'h00, 8'h00, 8'h00, 8'h00};
endpackage

// [rtl/ics_bus_if.sv]
// Purpose: two-wire bus between master and slave ends
// Assumes: open drain, pull-up when nobody drives
// Notes: oe is active low (low = driving low)
`timescale 1ns/1ns
interface ics_bus_if;
  logic scl_oe_n;
  logic sda_m_oe_n;
  logic sda_s_oe_n;
  logic scl;
  logic sda;
  assign scl = scl_oe_n;
  assign sda = sda_m_oe_n & sda_s_oe_n;
  modport master (output scl_oe_n, output sda_m_oe_n, input scl, input sda);
  modport slave (output sda_s_oe_n, input scl, input sda);
endinterface

// [rtl/ics_sync.sv]
// Purpose: two-flop synchroniser for pin inputs
// Assumes: one clock
// Notes: first stage feeds only the second
`timescale 1ns/1ns
module ics_sync #(
  parameter int W = 1
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] meta;
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      meta <= '1;
      dout <= '1;
    end else begin
      meta <= din;
      dout <= meta;
    end
  end
endmodule // ics_sync

// [rtl/ics_slave.sv]
// Purpose: device end, slave receiver/transmitter with 16 registers
// Assumes: scl and sda sampled on ref_clk, reset synchronous
// Notes: register contents exposed as a flat vector
`timescale 1ns/1ns
module ics_slave (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic enable,
  input wire logic scan_mode,
  input wire logic addr_strap_bit0,
  input wire logic addr_strap_bit1,
  ics_bus_if.slave bus,
  output logic [8*ics_pkg::REG_COUNT-1:0] reg_bank,
  output logic sleeping
);
  import ics_pkg::*;
  typedef enum {S_IDLE, S_STRT, S_ADDR, S_AACK, S_SUB, S_SACK, S_WDAT, S_WACK, S_RDAT,
    S_RNXT, S_RACK, S_IGN} ics_sst_t;
  ics_sst_t state;
  logic [2:0] pins;
  logic en_s, scan_s, a0_s, a1_s, scl_s, sda_s;
  logic scl_d, sda_d;
  logic [7:0] shreg;
  logic [2:0] bitc;
  logic [SUB_W-1:0] sub;
  logic sub_ok;
  logic drive_low;
  logic [7:0] regs [0:REG_COUNT-1];
  // pull the line low for a zero; bits leave msb first
  function automatic logic bit_low(input logic [7:0] b, input logic [2:0] i);
    return ~b[3'h7 - i];
  endfunction
  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  ics_sync #(.W(3)) u_pins (.ref_clk(ref_clk), .reset(reset),
    .din({enable, addr_strap_bit1, addr_strap_bit0}), .dout(pins));
  ics_sync #(.W(3)) u_scan (.ref_clk(ref_clk), .reset(reset),
    .din({scan_mode, bus.scl, bus.sda}), .dout({scan_s, scl_s, sda_s}));
  assign en_s = pins[2];
  assign a1_s = pins[1];
  assign a0_s = pins[0];
  // the two-cycle pin lag is far below one bit time on the bus
  // ----------------------------------------
  // conditions
  // ----------------------------------------
  // sleep when enable low
  wire asleep = ~en_s;
  wire active = en_s & ~scan_s;
  // conditions need two sampled levels, yet an sda glitch caught by one sample still fires a start or stop
  wire scl_rise = scl_s & ~scl_d;
  wire scl_fall = ~scl_s & scl_d;
  wire start_c = scl_s & scl_d & sda_d & ~sda_s;
  wire stop_c = scl_s & scl_d & ~sda_d & sda_s;
  wire addr_hit = shreg[7:1] == {ADDR_FIXED, a1_s, a0_s};
  // straps are read live, so move them only while the bus is idle
  wire [7:0] next_shreg = {shreg[6:0], sda_s};
  wire [7:0] rd_byte = regs[sub];
  // nothing to do here: an open reset pin already reads as run
  // pad pull-down holds reset low, so the part runs
  assign sleeping = asleep;
  // gated by active so sleep or scan lets go of sda at once, not an edge later
  // slave only, never scl
  assign bus.sda_s_oe_n = ~(drive_low & active);
  // flat view of the bank for whoever needs the settings
  genvar g;
  for (g = 0; g < REG_COUNT; g++) begin : g_out
    assign reg_bank[8*g +: 8] = regs[g];
  end
  // ----------------------------------------
  // line history
  // ----------------------------------------
  // history runs even when the port is blocked, so waking mid-frame
  // cannot see a start from stale idle levels
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= scl_s;
      sda_d <= sda_s;
    end
  end
  // ----------------------------------------
  // bit level state machine
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    if (reset || !active) begin
      state <= S_IDLE;
      shreg <= 8'h00;
      bitc <= 3'h0;
      sub <= '0;
      sub_ok <= 1'b0;
      drive_low <= 1'b0;
    end else begin
      if (start_c) begin
        state <= S_STRT;
        bitc <= 3'h0;
        sub_ok <= 1'b0;
        drive_low <= 1'b0;
      end else if (stop_c) begin
        state <= S_IDLE;
        drive_low <= 1'b0;
      end else if (scl_rise) begin
        unique case (state)
          S_ADDR, S_SUB, S_WDAT: begin
            shreg <= next_shreg;
            bitc <= bitc + 3'h1;
          end
          S_RACK: begin
            state <= sda_s ? S_IGN : S_RNXT;
          end
          default: ;
        endcase
      end else if (scl_fall) begin
        unique case (state)
          S_STRT: begin
            // the fall that closes a start carries no bit
            state <= S_ADDR;
          end
          S_ADDR: begin
            if (bitc == 3'h0) begin
              if (addr_hit) begin
                state <= S_AACK;
                drive_low <= 1'b1;
              end else begin
                state <= S_IGN;
              end
            end
          end
          S_AACK: begin
            if (shreg[0]) begin
              state <= S_RDAT;
              shreg <= rd_byte;
              drive_low <= bit_low(rd_byte, 3'h0);
              bitc <= 3'h1;
            end else begin
              state <= S_SUB;
              drive_low <= 1'b0;
              bitc <= 3'h0;
            end
          end
          S_RNXT: begin
            state <= S_RDAT;
            shreg <= rd_byte;
            drive_low <= bit_low(rd_byte, 3'h0);
            bitc <= 3'h1;
          end
          S_SUB: begin
            if (bitc == 3'h0) begin
              sub <= shreg[SUB_W-1:0];
              sub_ok <= 1'b1;
              state <= S_SACK;
              drive_low <= 1'b1;
            end
          end
          S_SACK, S_WACK: begin
            state <= S_WDAT;
            drive_low <= 1'b0;
            bitc <= 3'h0;
          end
          S_WDAT: begin
            if (bitc == 3'h0) begin
              state <= S_WACK;
              drive_low <= 1'b1;
            end
          end
          S_RDAT: begin
            // shift read data out msb first
            if (bitc == 3'h0) begin
              state <= S_RACK;
              drive_low <= 1'b0;
              sub <= sub + 1'b1;
            end else begin
              drive_low <= bit_low(shreg, bitc);
              bitc <= bitc + 3'h1;
            end
          end
          default: ;
        endcase
      end
    end
  end
  // ----------------------------------------
  // register bank
  // ----------------------------------------
  // sub_ok is cleared by every start, so a frame cut before its
  // sub-address can never write through a stale pointer
  wire wr_now = active && scl_fall && state == S_WDAT && bitc == 3'h0 && sub_ok;
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      for (int i = 0; i < REG_COUNT; i++) begin
        regs[i] <= REG_RESET[i];
      end
    end else if (asleep) begin
      // deep sleep clears the power-down bit
      regs[0][0] <= 1'b0;
    end else if (wr_now) begin
      regs[sub] <= shreg;
    end
  end
endmodule // ics_slave

// [rtl/ics_master.sv]
// Purpose: host end, issues register writes and reads
// Assumes: one request at a time; req held until done
// Notes: one data byte per transfer
`timescale 1ns/1ns
module ics_master (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic req,
  input wire logic rd,
  input wire logic [1:0] dev_sel,
  input wire logic [3:0] sub_addr,
  input wire logic [7:0] wdata,
  output logic done,
  output logic nack,
  output logic [7:0] rdata,
  ics_bus_if.master bus
);
  import ics_pkg::*;
  typedef enum {M_IDLE, M_START, M_BIT, M_STOP} ics_mst_t;
  ics_mst_t state;
  logic [1:0] phase;
  logic [7:0] cnt;
  logic [5:0] bitn;
  logic [35:0] frame;
  logic [5:0] last;
  logic scl_drv, sda_drv;
  logic sda_s;
  // only sda is read back: the slave never stretches scl
  ics_sync #(.W(1)) u_in (.ref_clk(ref_clk), .reset(reset),
    .din(bus.sda), .dout(sda_s));
  wire tick = cnt == 8'(QTR_CYC - 1);
  assign bus.scl_oe_n = scl_drv;
  assign bus.sda_m_oe_n = sda_drv;
  wire [7:0] adr_w = {ADDR_FIXED, dev_sel, 1'b0};
  wire [7:0] adr_r = {ADDR_FIXED, dev_sel, 1'b1};
  // ----------------------------------------
  // bit sequencer: each slot is 9 bits incl. ack
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state <= M_IDLE;
      cnt <= 8'h00;
      phase <= 2'h0;
      bitn <= 6'h00;
      frame <= 36'h0;
      last <= 6'h00;
      scl_drv <= 1'b1;
      sda_drv <= 1'b1;
      done <= 1'b0;
      nack <= 1'b0;
      rdata <= 8'h00;
    end else begin
      done <= 1'b0;
      cnt <= tick ? 8'h00 : cnt + 8'h01;
      unique case (state)
        M_IDLE: begin
          if (req && !done) begin
            // write: address, sub, data; read: one byte, then nack
            frame <= rd ? {adr_r, 1'b1, 8'hFF, 1'b1, 18'h0} :
              {adr_w, 1'b1, 4'h0, sub_addr, 1'b1, wdata, 1'b1, 9'h0};
            last <= rd ? 6'd17 : 6'd26;
            nack <= 1'b0;
            state <= M_START;
            cnt <= 8'h00;
          end
        end
        M_START: if (tick) begin
          sda_drv <= 1'b0;
          phase <= 2'h0;
          bitn <= 6'h00;
          state <= M_BIT;
        end
        M_BIT: if (tick) begin
          phase <= phase + 2'h1;
          unique case (phase)
            2'h0: begin
              scl_drv <= 1'b0;
            end
            2'h1: begin
              sda_drv <= frame[35];
            end
            2'h2: begin
              scl_drv <= 1'b1;
            end
            2'h3: begin
              frame <= {frame[34:0], 1'b0};
              if (bitn == 6'd8 || bitn == 6'd17 || bitn == 6'd26) begin
                if (sda_s && !(rd && bitn == 6'd17)) nack <= 1'b1;
              end else if (rd && bitn > 6'd8) begin
                rdata <= {rdata[6:0], sda_s};
              end
              bitn <= bitn + 6'h01;
              if (bitn == last || (bitn == 6'd8 && sda_s)) state <= M_STOP;
            end
          endcase
        end
        M_STOP: if (tick) begin
          phase <= phase + 2'h1;
          if (phase == 2'h0) scl_drv <= 1'b0;
          if (phase == 2'h1) sda_drv <= 1'b0;
          if (phase == 2'h2) scl_drv <= 1'b1;
          if (phase == 2'h3) begin
            sda_drv <= 1'b1;
            done <= 1'b1;
            state <= M_IDLE;
          end
        end
      endcase
    end
  end
endmodule // ics_master

// [testbench/ics_asserts.sv]
// Purpose: wire checks on the two-wire port
// Assumes: one clock, sync reset
// Notes: helpers count scl phases
`timescale 1ns/1ns
module ics_asserts (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic enable,
  input wire logic scan_mode,
  input wire logic sleeping,
  input wire logic scl,
  input wire logic sda_s_oe_n
);
  import ics_pkg::*;
  // --
  // helpers
  // --
  logic scl_q;
  logic [7:0] per_cnt;
  logic [7:0] hi_cnt;
  wire scl_up = scl & ~scl_q;
  wire scl_dn = ~scl & scl_q;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  // saturate so idle gaps never wrap into a short period
  always_ff @(posedge ref_clk) begin
    scl_q <= scl;
    per_cnt <= reset ? 8'hFF : scl_up ? 8'h00 : per_cnt + {7'h00, per_cnt != 8'hFF};
    hi_cnt <= (reset || !scl) ? 8'h00 : hi_cnt + {7'h00, hi_cnt != 8'hFF};
  end
  sequence s_asleep; !enable [*3]; endsequence
  sequence s_awake; enable [*3]; endsequence
  property p_sleep_flag; s_asleep |-> sleeping; endproperty
  a_sleep_flag: assert property (p_sleep_flag) else $error("no sleep flag");
  property p_wake_flag; s_awake |-> !sleeping; endproperty
  a_wake_flag: assert property (p_wake_flag) else $error("sleep flag stuck");
  property p_sleep_quiet; sleeping |-> sda_s_oe_n; endproperty
  a_sleep_quiet: assert property (p_sleep_quiet) else $error("driven asleep");
  property p_scan_quiet; scan_mode [*3] |-> sda_s_oe_n; endproperty
  a_scan_quiet: assert property (p_scan_quiet) else $error("driven in scan");
  property p_slave_only; $changed(sda_s_oe_n) |-> !scl; endproperty
  a_slave_only: assert property (p_slave_only) else $error("sda moved, scl high");
  property p_rate; scl_up |-> per_cnt >= 8'd24; endproperty
  a_rate: assert property (p_rate) else $error("scl too fast");
  property p_high; scl_dn |-> hi_cnt >= 8'(2 * QTR_CYC); endproperty
  a_high: assert property (p_high) else $error("scl high too short");
  property p_drive_bounded; $fell(sda_s_oe_n) |-> ##[1:300] sda_s_oe_n; endproperty
  a_drive_bounded: assert property (p_drive_bounded) else $error("sda held");
endmodule // ics_asserts

// [testbench/i2c_slave_control_port_tb.sv]
// Purpose: bench joining both ends of the two-wire port
// Assumes: 10 MHz ref_clk, sync reset
// Notes: model holds registers and read pointer
`timescale 1ns/1ns
module i2c_slave_control_port_tb;
  import ics_pkg::*;
  logic ref_clk, reset, enable, scan_mode, req, rd, done, nack, sleeping;
  logic [1:0] strap, dev_sel;
  logic [3:0] sub_addr, ptr;
  logic [7:0] wdata, rdata;
  logic [127:0] reg_bank;
  logic [7:0] model [16];
  int failures, check_count, seed;
  logic rst_float;
  tri0 rst_pin;
  assign rst_pin = rst_float ? 1'bz : reset;
  ics_bus_if ics_bus_if_i ();
  ics_slave ics_slave_i (.ref_clk(ref_clk), .reset(rst_pin), .enable(enable),
    .scan_mode(scan_mode), .addr_strap_bit0(strap[0]), .addr_strap_bit1(strap[1]),
    .bus(ics_bus_if_i.slave), .reg_bank(reg_bank), .sleeping(sleeping));
  ics_master ics_master_i (.ref_clk(ref_clk), .reset(reset), .req(req), .rd(rd),
    .dev_sel(dev_sel), .sub_addr(sub_addr), .wdata(wdata), .done(done), .nack(nack),
    .rdata(rdata), .bus(ics_bus_if_i.master));
  ics_asserts ics_asserts_i (.ref_clk(ref_clk), .reset(reset), .enable(enable),
    .scan_mode(scan_mode), .sleeping(sleeping), .scl(ics_bus_if_i.scl),
    .sda_s_oe_n(ics_bus_if_i.sda_s_oe_n));
  initial begin
    ref_clk = 0;
    forever #50 ref_clk = ~ref_clk;
  end
  // --
  // tasks
  // --
  task automatic give_verdict;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", nm, exp, got);
      failures++;
    end
  endtask
  // one whole transfer; req held until done, as the master expects
  task automatic xfer(input logic r, input logic [1:0] s, input logic [3:0] a);
    int n;
    logic hit;
    hit = enable && !scan_mode && s == strap;
    @(posedge ref_clk);
    #10;
    req = 1;
    rd = r;
    dev_sel = s;
    sub_addr = a;
    wdata = 8'($random(seed));
    n = 0;
    do begin
      @(posedge ref_clk);
      #1;
      n++;
    end while (done !== 1'b1 && n < 3000);
    #9;
    req = 0;
    if (n >= 3000) begin
      failures++;
      give_verdict();
    end
    chk("nack", {7'h00, !hit}, {7'h00, nack});
    if (hit && r) begin
      chk("rdata", model[ptr], rdata);
      ptr++;
    end else if (hit) begin
      model[a] = wdata;
      ptr = a;
    end
    for (int i = 0; i < REG_COUNT; i++) chk("reg_bank", model[i], reg_bank[8*i +: 8]);
  endtask
  initial begin
    seed = 32'he5b7;
    failures = 0;
    check_count = 0;
    {reset, enable, scan_mode, req, rd} = 5'h18;
    {dev_sel, sub_addr, wdata, strap, ptr} = 20'h00000;
    rst_float = 0;
    for (int i = 0; i < REG_COUNT; i++) model[i] = REG_RESET[i];
    repeat (5) @(posedge ref_clk);
    #10;
    reset = 0;
    // pointer walk past the last register wraps to the first
    repeat (17) xfer(1, 2'h0, 4'h0);
    for (int k = 0; k < 16; k++) begin
      strap = 2'(k >> 2);
      xfer(0, 2'(k), 4'($random(seed)));
      xfer(1, 2'(k), 4'h0);
    end
    enable = 0;
    repeat (4) @(posedge ref_clk);
    #1;
    chk("sleeping", 8'h01, {7'h00, sleeping});
    model[0][0] = 1'b0;
    xfer(0, strap, 4'h3);
    enable = 1;
    repeat (4) @(posedge ref_clk);
    xfer(0, strap, 4'h2);
    xfer(1, strap, 4'h0);
    scan_mode = 1;
    repeat (4) @(posedge ref_clk);
    xfer(0, strap, 4'h5);
    scan_mode = 0;
    rst_float = 1;
    repeat (4) @(posedge ref_clk);
    xfer(0, strap, 4'hF);
    xfer(1, strap, 4'h0);
    xfer(1, strap, 4'h0);
    give_verdict();
  end
endmodule // i2c_slave_control_port_tb
